// File: hdl/cml_regs.svh
// register offsets, field positions, reset values and phase counts of the executor
`ifndef CML_REGS_SVH
`define CML_REGS_SVH

`define CML_OFS_ACC       8'h00
`define CML_OFS_BANK      8'h04
`define CML_OFS_STATUS    8'h08
`define CML_OFS_PRODUCT_LOW_BYTE     8'h0c
`define CML_OFS_PRODUCT_HIGH_BYTE     8'h10
`define CML_OFS_PTR0      8'h14
`define CML_OFS_PTR_STEP  8'h04
`define CML_OFS_STATE     8'h20

`define CML_STATUS_Z      0
`define CML_STATUS_N      4
`define CML_BIT_A         8
`define CML_BIT_D         9

`define CML_RST_BYTE      8'h00
`define CML_RST_PTR       12'h000
`define CML_RST_WORD      16'h0000

`define CML_ACC_ADDR      12'hff0
`define CML_ACCESS_SPLIT  8'h80
`define CML_ACCESS_HI     4'hf
`define CML_ACCESS_LO     4'h0

`define CML_Q_TAKE        2'h0
`define CML_Q_READ        2'h1
`define CML_Q_HOLD        2'h2
`define CML_Q_WRITE       2'h3
`define CML_Q_STEP        2'h1

`endif

// File: hdl/cml_pkg.sv
// types shared by the instruction executor and its data memory
package cml_pkg;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_FIRST  = 3'b010,
    ST_SECOND = 3'b100
  } cml_fsm_t;

  typedef enum logic [3:0] {
    OP_NOP              = 4'h0,
    OP_OR_LITERAL       = 4'h1,
    OP_OR_FILE          = 4'h2,
    OP_LOAD_POINTER     = 4'h3,
    OP_MOVE_FILE        = 4'h4,
    OP_MOVE_FILE_TO_FILE = 4'h5,
    OP_LOAD_BANK        = 4'h6,
    OP_LOAD_ACC         = 4'h7,
    OP_STORE_ACC        = 4'h8,
    OP_MULTIPLY_LITERAL = 4'h9,
    OP_MULTIPLY_FILE    = 4'ha
  } cml_op_t;

  typedef struct packed {
    logic        valid;
    logic        skip;
    logic [15:0] word;
  } cml_ins_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } cml_bus_t;

endpackage

// File: hdl/cml_data_ram.sv
// data memory with one write port and a registered read port
`timescale 1ns/1ns
module cml_data_ram #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  // clock and reset
  input  wire logic          i_mclk,
  input  wire logic          i_rst_b,
  input  wire logic          i_ce,
  // write port
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [DW-1:0] i_wdata,
  // read port
  input  wire logic          i_re,
  input  wire logic [AW-1:0] i_raddr,
  output logic      [DW-1:0] o_rdata
);
  import cml_pkg::*;

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge i_mclk) begin
    if (i_ce && i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= '0;
    end else if (i_ce && i_re) begin
      o_rdata <= mem[i_raddr];
    end
  end

endmodule

// File: hdl/cml_exec_core.sv
// executor for logic, move and multiply instructions of an 8-bit core
// Summary of operation
// RQ1: or_literal_into_acc ORs an 8-bit literal into the accumulator, setting only N and Z.
// RQ2: or_acc_with_file ORs accumulator and file into acc (d=0) or file (d=1), setting N and Z.
// RQ3: a bank bit of 0 selects the access bank, a bank bit of 1 the bank named by bank_select_reg.
// RQ4: load_pointer_literal writes a 12-bit pointer, high nibble in cycle one, low byte in two.
// RQ5: move_file_to_file copies any 12-bit data-space location to any other.
// RQ6: move_file_to_file treats the accumulator as an ordinary source or destination location.
// RQ7: software never names program_counter_low or a stack top byte as the move destination.
// RQ8: load_bank_literal loads all 8 literal bits into bank_select_reg, flags untouched.
// RQ9: load_acc_literal loads an 8-bit literal into the accumulator, flags untouched.
// RQ10: multiply_acc_literal puts acc times literal, unsigned, in the product pair; acc kept.
// RQ11: both multiplies: high byte to product_high_byte, low byte to product_low_byte.
// RQ12: neither multiply changes any status flag.
// RQ13: a zero product is written with no flag raised.
// RQ14: move_file copies a file to the accumulator (d=0) or to itself (d=1), setting N and Z.
// RQ15: store_acc_to_file writes the accumulator to the file in one cycle, flags untouched.
// RQ16: move_file_to_file takes two cycles; the second word supplies the destination, written with no read before it.
`timescale 1ns/1ns
`include "cml_regs.svh"
module cml_exec_core #(
  parameter int AW       = 12,
  parameter int PTR_CNT  = 3
) (
  // clock and reset
  input  wire logic              i_mclk,
  input  wire logic              i_rst_b,
  input  wire logic              i_ce,
  // instruction stream
  input  wire cml_pkg::cml_ins_t i_ins,
  output logic                   o_ins_ready,
  // register port
  input  wire cml_pkg::cml_bus_t i_bus,
  output logic [31:0]            o_rdata
);
  import cml_pkg::*;

  typedef struct packed {
    cml_fsm_t                  fsm;
    logic [1:0]                q;
    cml_op_t                   op;
    logic                      skip;
    logic                      have2;
    logic                      rd_acc;
    logic [1:0]                sel;
    logic [15:0]               ins;
    logic [7:0]                hold;
    logic [7:0]                acc;
    logic [7:0]                bank_select_reg;
    logic [7:0]                product_low_byte;
    logic [7:0]                product_high_byte;
    logic                      flag_n;
    logic                      flag_z;
    logic [PTR_CNT-1:0][11:0]  ptr;
    logic [31:0]               rdata;
  } cml_state_t;

  cml_state_t    st_reg;
  cml_state_t    st_next;
  logic          mem_we;
  logic          mem_re;
  logic [AW-1:0] mem_waddr;
  logic [AW-1:0] mem_raddr;
  logic [7:0]    mem_wdata;
  logic [7:0]    mem_rdata;
  logic [11:0]   file_addr;
  logic [15:0]   prod_file;
  logic [15:0]   prod_lit;
  logic [31:0]   rd_val;
  logic          wr_en;
  logic [11:0]   wr_addr;
  logic [7:0]    wr_val;
  logic [7:0]    res;
  logic          first_wr;
  logic          second_wr;

  ////////////////////////////////////////////////////////////////////////////
  // decode and address helpers

  function automatic cml_op_t decode(input logic [15:0] w);
    cml_op_t op;
    casez (w)
      16'b0000_1001_????_????: op = OP_OR_LITERAL;
      16'b0001_00??_????_????: op = OP_OR_FILE;
      16'b1110_1110_00??_????: op = OP_LOAD_POINTER;
      16'b0101_00??_????_????: op = OP_MOVE_FILE;
      16'b1100_????_????_????: op = OP_MOVE_FILE_TO_FILE;
      16'b0000_0001_????_????: op = OP_LOAD_BANK;
      16'b0000_1110_????_????: op = OP_LOAD_ACC;
      16'b0110_111?_????_????: op = OP_STORE_ACC;
      16'b0000_1101_????_????: op = OP_MULTIPLY_LITERAL;
      16'b0000_001?_????_????: op = OP_MULTIPLY_FILE;
      default:                 op = OP_NOP;
    endcase
    return op;
  endfunction

  // banked file address; the two-word move carries a full address instead
  always_comb begin
    if (st_reg.op == OP_MOVE_FILE_TO_FILE) begin
      file_addr = st_reg.ins[11:0]; // [RQ5]
    end else if (st_reg.ins[`CML_BIT_A]) begin
      file_addr = {st_reg.bank_select_reg[3:0], st_reg.ins[7:0]}; // [RQ3]
    end else if (st_reg.ins[7:0] < `CML_ACCESS_SPLIT) begin
      file_addr = {`CML_ACCESS_LO, st_reg.ins[7:0]}; // [RQ3]
    end else begin
      file_addr = {`CML_ACCESS_HI, st_reg.ins[7:0]}; // [RQ3]
    end
  end

  assign prod_file   = {8'h00, st_reg.acc} * {8'h00, st_reg.hold};
  assign prod_lit    = {8'h00, st_reg.acc} * {8'h00, st_reg.ins[7:0]};
  assign first_wr    = (st_reg.fsm == ST_FIRST) && (st_reg.q == `CML_Q_WRITE) && !st_reg.skip;
  assign second_wr   = (st_reg.fsm == ST_SECOND) && (st_reg.q == `CML_Q_WRITE) &&
                       st_reg.have2 && !st_reg.skip;
  assign o_ins_ready = (st_reg.q == `CML_Q_TAKE) &&
                       ((st_reg.fsm == ST_IDLE) || (st_reg.fsm == ST_SECOND && !st_reg.have2));
  assign o_rdata     = st_reg.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // register port read mux

  always_comb begin
    rd_val = 32'h0000_0000;
    case (i_bus.addr)
      `CML_OFS_ACC:    rd_val = {24'h000000, st_reg.acc};
      `CML_OFS_BANK:   rd_val = {24'h000000, st_reg.bank_select_reg};
      `CML_OFS_STATUS: begin
        rd_val[`CML_STATUS_N] = st_reg.flag_n;
        rd_val[`CML_STATUS_Z] = st_reg.flag_z;
      end
      `CML_OFS_PRODUCT_LOW_BYTE:  rd_val = {24'h000000, st_reg.product_low_byte};
      `CML_OFS_PRODUCT_HIGH_BYTE:  rd_val = {24'h000000, st_reg.product_high_byte};
      `CML_OFS_STATE:  rd_val = {22'h000000, st_reg.skip, st_reg.q, st_reg.op, st_reg.fsm};
      default:         rd_val = 32'h0000_0000;
    endcase
    for (int i = 0; i < PTR_CNT; i++) begin
      if (i_bus.addr == `CML_OFS_PTR0 + 8'(i * 4)) begin
        rd_val = {20'h00000, st_reg.ptr[i]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_next   = st_reg;
    mem_re    = 1'b0;
    mem_raddr = file_addr;
    wr_en     = 1'b0;
    wr_addr   = file_addr;
    wr_val    = st_reg.acc;
    res       = 8'h00;
    st_next.rdata = i_bus.rd ? rd_val : 32'h0000_0000;
    st_next.q     = st_reg.q + `CML_Q_STEP;
    // software writes first, instruction results override them
    if (i_bus.wr) begin
      case (i_bus.addr)
        `CML_OFS_ACC:    st_next.acc = i_bus.wdata[7:0];
        `CML_OFS_BANK:   st_next.bank_select_reg = i_bus.wdata[7:0];
        `CML_OFS_STATUS: begin
          st_next.flag_n = i_bus.wdata[`CML_STATUS_N];
          st_next.flag_z = i_bus.wdata[`CML_STATUS_Z];
        end
        `CML_OFS_PRODUCT_LOW_BYTE:  st_next.product_low_byte = i_bus.wdata[7:0];
        `CML_OFS_PRODUCT_HIGH_BYTE:  st_next.product_high_byte = i_bus.wdata[7:0];
        default: ;
      endcase
      for (int i = 0; i < PTR_CNT; i++) begin
        if (i_bus.addr == `CML_OFS_PTR0 + 8'(i * 4)) begin
          st_next.ptr[i] = i_bus.wdata[11:0];
        end
      end
    end
    unique case (st_reg.fsm)
      ST_IDLE: begin
        if (o_ins_ready && i_ins.valid) begin
          st_next.fsm  = ST_FIRST;
          st_next.ins  = i_ins.word;
          st_next.op   = decode(i_ins.word);
          st_next.skip = i_ins.skip;
        end
      end
      ST_FIRST: begin
        if (st_reg.q == `CML_Q_READ) begin
          mem_re         = !st_reg.skip;
          st_next.rd_acc = (file_addr == `CML_ACC_ADDR); // [RQ6]
        end
        if (st_reg.q == `CML_Q_HOLD) begin
          st_next.hold = st_reg.rd_acc ? st_reg.acc : mem_rdata;
        end
        if (first_wr) begin
          unique case (st_reg.op)
            OP_OR_LITERAL: begin
              res         = st_reg.acc | st_reg.ins[7:0];
              st_next.acc = res; // [RQ1]
            end
            OP_OR_FILE: begin
              res     = st_reg.acc | st_reg.hold;
              wr_en   = st_reg.ins[`CML_BIT_D]; // [RQ2]
              wr_val  = res;
              if (!st_reg.ins[`CML_BIT_D]) begin
                st_next.acc = res; // [RQ2]
              end
            end
            OP_MOVE_FILE: begin
              res    = st_reg.hold;
              wr_en  = st_reg.ins[`CML_BIT_D]; // [RQ14]
              wr_val = res;
              if (!st_reg.ins[`CML_BIT_D]) begin
                st_next.acc = res; // [RQ14]
              end
            end
            OP_STORE_ACC: wr_en = 1'b1; // [RQ15]
            OP_LOAD_BANK: st_next.bank_select_reg = st_reg.ins[7:0]; // [RQ8]
            OP_LOAD_ACC:  st_next.acc = st_reg.ins[7:0]; // [RQ9]
            OP_MULTIPLY_LITERAL: begin
              st_next.product_high_byte = prod_lit[15:8]; // [RQ10] [RQ11]
              st_next.product_low_byte = prod_lit[7:0]; // [RQ10] [RQ11]
            end
            OP_MULTIPLY_FILE: begin
              st_next.product_high_byte = prod_file[15:8]; // [RQ11]
              st_next.product_low_byte = prod_file[7:0]; // [RQ11]
            end
            OP_LOAD_POINTER: begin
              st_next.sel = st_reg.ins[5:4];
              if (32'(st_reg.ins[5:4]) < PTR_CNT) begin
                st_next.ptr[st_reg.ins[5:4]][11:8] = st_reg.ins[3:0]; // [RQ4]
              end
            end
            default: ;
          endcase
          // only the logic and move-file forms touch the flags
          if (st_reg.op inside {OP_OR_LITERAL, OP_OR_FILE, OP_MOVE_FILE}) begin // [RQ12] [RQ13]
            st_next.flag_n = res[7]; // [RQ1] [RQ2] [RQ14]
            st_next.flag_z = (res == 8'h00); // [RQ1] [RQ2] [RQ14]
          end
        end
        if (st_reg.q == `CML_Q_WRITE) begin
          st_next.have2 = 1'b0;
          if (st_reg.op inside {OP_LOAD_POINTER, OP_MOVE_FILE_TO_FILE}) begin
            st_next.fsm = ST_SECOND; // [RQ16]
          end else begin
            st_next.fsm = ST_IDLE;
          end
        end
      end
      ST_SECOND: begin
        // second word is taken but only read as data: no decode
        if (o_ins_ready && i_ins.valid) begin
          st_next.have2 = 1'b1; // [RQ16]
          if (st_reg.op == OP_LOAD_POINTER) begin
            st_next.ins = i_ins.word;
          end else begin
            st_next.ins = {st_reg.ins[15:12], i_ins.word[11:0]};
          end
        end
        if (second_wr) begin
          if (st_reg.op == OP_MOVE_FILE_TO_FILE) begin
            wr_en   = 1'b1; // [RQ5] [RQ16]
            wr_addr = st_reg.ins[11:0]; // [RQ5]
            wr_val  = st_reg.hold;
          end else if (32'(st_reg.sel) < PTR_CNT) begin
            st_next.ptr[st_reg.sel][7:0] = st_reg.ins[7:0]; // [RQ4]
          end
        end
        if (st_reg.q == `CML_Q_WRITE && st_reg.have2) begin
          st_next.fsm = ST_IDLE;
        end
      end
    endcase
    // destination routing: the accumulator is part of the data space
    mem_we    = wr_en && (wr_addr != `CML_ACC_ADDR);
    mem_waddr = wr_addr;
    mem_wdata = wr_val;
    if (wr_en && wr_addr == `CML_ACC_ADDR) begin
      st_next.acc = wr_val; // [RQ6]
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_reg        <= '0;
      st_reg.fsm    <= ST_IDLE;
      st_reg.q      <= `CML_Q_TAKE;
      st_reg.acc    <= `CML_RST_BYTE;
      st_reg.bank_select_reg    <= `CML_RST_BYTE;
      st_reg.product_low_byte  <= `CML_RST_BYTE;
      st_reg.product_high_byte  <= `CML_RST_BYTE;
      st_reg.ptr    <= {PTR_CNT{`CML_RST_PTR}};
    end else if (i_ce) begin
      st_reg <= st_next;
    end
  end

  cml_data_ram #(
    .AW (AW),
    .DW (8)
  ) u_ram (
    .i_mclk  (i_mclk),
    .i_rst_b (i_rst_b),
    .i_ce    (i_ce),
    .i_we    (mem_we),
    .i_waddr (mem_waddr),
    .i_wdata (mem_wdata),
    .i_re    (mem_re),
    .i_raddr (mem_raddr),
    .o_rdata (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);

  AST_OR_LIT: assert property (first_wr && i_ce && st_reg.op == OP_OR_LITERAL |=> // [RQ1]
      st_reg.acc == ($past(st_reg.acc) | $past(st_reg.ins[7:0])) &&
      st_reg.flag_z == (st_reg.acc == 8'h00) && st_reg.flag_n == st_reg.acc[7])
    else $error("literal OR result or flags wrong");
  AST_OR_FILE: assert property (first_wr && i_ce && st_reg.op == OP_OR_FILE && // [RQ2]
      !st_reg.ins[`CML_BIT_D] |=> st_reg.acc == ($past(st_reg.acc) | $past(st_reg.hold)))
    else $error("file OR to accumulator wrong");
  AST_ACCESS_BANK: assert property (st_reg.fsm == ST_FIRST && st_reg.q == `CML_Q_READ && // [RQ3]
      st_reg.op != OP_MOVE_FILE_TO_FILE |-> (st_reg.ins[`CML_BIT_A] ?
      mem_raddr[11:8] == st_reg.bank_select_reg[3:0] : mem_raddr[11:8] inside {4'h0, 4'hf}))
    else $error("bank selection wrong");
  AST_PTR_LOW: assert property (second_wr && i_ce && st_reg.op == OP_LOAD_POINTER && // [RQ4]
      st_reg.sel == 2'h0 |=> st_reg.ptr[0][7:0] == $past(st_reg.ins[7:0]))
    else $error("pointer low byte not loaded");
  AST_F2F_WRITE: assert property (second_wr && st_reg.op == OP_MOVE_FILE_TO_FILE && // [RQ5]
      st_reg.ins[11:0] != `CML_ACC_ADDR |-> mem_we && mem_waddr == st_reg.ins[11:0] &&
      mem_wdata == st_reg.hold)
    else $error("memory move destination write wrong");
  AST_F2F_ACC: assert property (second_wr && i_ce && st_reg.op == OP_MOVE_FILE_TO_FILE && // [RQ6]
      st_reg.ins[11:0] == `CML_ACC_ADDR |=> st_reg.acc == $past(st_reg.hold))
    else $error("memory move into accumulator wrong");
  AST_BANK_LIT: assert property (first_wr && i_ce && st_reg.op == OP_LOAD_BANK |=> // [RQ8]
      st_reg.bank_select_reg == $past(st_reg.ins[7:0]) && $stable(st_reg.flag_z) && $stable(st_reg.flag_n))
    else $error("bank literal load wrong");
  AST_ACC_LIT: assert property (first_wr && i_ce && st_reg.op == OP_LOAD_ACC |=> // [RQ9]
      st_reg.acc == $past(st_reg.ins[7:0]) && $stable(st_reg.flag_z))
    else $error("accumulator literal load wrong");
  AST_MUL_LIT: assert property (first_wr && i_ce && st_reg.op == OP_MULTIPLY_LITERAL |=> // [RQ10]
      {st_reg.product_high_byte, st_reg.product_low_byte} == $past(prod_lit) && $stable(st_reg.acc))
    else $error("literal multiply wrong");
  AST_MUL_FILE: assert property (first_wr && i_ce && st_reg.op == OP_MULTIPLY_FILE |=> // [RQ11]
      {st_reg.product_high_byte, st_reg.product_low_byte} == 16'($past(st_reg.acc)) * 16'($past(st_reg.hold)))
    else $error("file multiply byte order wrong");
  AST_MUL_FLAGS: assert property (first_wr && i_ce && // [RQ12]
      st_reg.op inside {OP_MULTIPLY_LITERAL, OP_MULTIPLY_FILE} |=>
      $stable(st_reg.flag_n) && $stable(st_reg.flag_z))
    else $error("multiply changed a flag");
  AST_MUL_ZERO: assert property (first_wr && i_ce && st_reg.op == OP_MULTIPLY_LITERAL && // [RQ13]
      prod_lit == 16'h0000 |=> {st_reg.product_high_byte, st_reg.product_low_byte} == 16'h0000 && $stable(st_reg.flag_z))
    else $error("zero product flagged or lost");
  AST_MOVE_FILE: assert property (first_wr && i_ce && st_reg.op == OP_MOVE_FILE && // [RQ14]
      !st_reg.ins[`CML_BIT_D] |=> st_reg.acc == $past(st_reg.hold) &&
      st_reg.flag_z == (st_reg.acc == 8'h00))
    else $error("file move wrong");
  AST_STORE: assert property (first_wr && st_reg.op == OP_STORE_ACC && // [RQ15]
      file_addr != `CML_ACC_ADDR |-> mem_we && mem_wdata == st_reg.acc && mem_waddr == file_addr)
    else $error("accumulator store wrong");
  AST_F2F_TWO: assert property (st_reg.fsm == ST_FIRST && st_reg.q == `CML_Q_WRITE && // [RQ16]
      i_ce && st_reg.op == OP_MOVE_FILE_TO_FILE |=> st_reg.fsm == ST_SECOND && !mem_we)
    else $error("memory move not two cycles");

  COV_MUL: cover property (first_wr && i_ce && st_reg.op == OP_MULTIPLY_FILE);
  COV_F2F: cover property (second_wr && i_ce && st_reg.op == OP_MOVE_FILE_TO_FILE);
  COV_PTR: cover property (second_wr && i_ce && st_reg.op == OP_LOAD_POINTER);
  COV_SKIP: cover property (st_reg.fsm == ST_SECOND && st_reg.skip && st_reg.have2);

endmodule

// File: verif/tb.sv
// self-checking random and directed bench for the instruction executor
`timescale 1ns/1ns
module tb;
  import cml_pkg::*;
  logic        i_mclk = 1'b0;
  logic        i_rst_b = 1'b0;
  logic        i_ce = 1'b1;
  cml_ins_t    i_ins = '0;
  cml_bus_t    i_bus = '0;
  logic        o_ins_ready;
  logic [31:0] o_rdata;
  int          n_errors = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          t_take = 0;
  int          gap;
  logic [7:0]  acc = '0, bank_select_reg = '0, pl = '0, ph = '0;
  logic [7:0]  mem [4096];
  logic        n = 1'b0, z = 1'b0;
  logic [11:0] ad;

  cml_exec_core #(.AW(12), .PTR_CNT(3)) cml_exec_core_inst (
    .i_mclk      (i_mclk),
    .i_rst_b     (i_rst_b),
    .i_ce        (i_ce),
    .i_ins       (i_ins),
    .o_ins_ready (o_ins_ready),
    .i_bus       (i_bus),
    .o_rdata     (o_rdata)
  );

  always #5 i_mclk = ~i_mclk;
  always @(posedge i_mclk) cyc <= cyc + 1;

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic bus_wr(logic [7:0] a, logic [31:0] d);
    i_bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_mclk);
    i_bus <= '0;
    @(posedge i_mclk);
  endtask

  task automatic reg_rd(logic [7:0] a, logic [31:0] exp, string nm);
    i_bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: '0};
    @(posedge i_mclk);
    i_bus <= '0;
    @(negedge i_mclk);
    check(nm, o_rdata, exp);
    @(posedge i_mclk);
  endtask

  // offer a word and hold it until an edge with ready high
  task automatic issue(logic [15:0] w, logic s = 1'b0);
    logic r;
    i_ins <= '{valid: 1'b1, skip: s, word: w};
    for (int k = 0; k < 20; k++) begin
      @(negedge i_mclk);
      r = o_ins_ready;
      @(posedge i_mclk);
      if (r) break;
    end
    check("word taken", r, 1'b1);
    gap = cyc - t_take;
    t_take = cyc;
  endtask

  // release the stream and wait for the next instruction slot
  task automatic settle;
    i_ins <= '0;
    @(negedge i_mclk);
    for (int k = 0; k < 12 && o_ins_ready !== 1'b1; k++) @(negedge i_mclk);
    @(posedge i_mclk);
  endtask

  task automatic run(logic [15:0] w);
    issue(w);
    settle;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [11:0] fa(logic [7:0] f, logic a);
    if (a) return {bank_select_reg[3:0], f};
    return {(f >= 8'h80) ? 4'hf : 4'h0, f};
  endfunction

  function automatic logic [7:0] mrd(logic [11:0] x);
    return (x == 12'hff0) ? acc : mem[x];
  endfunction

  function automatic logic [7:0] pick();
    case ($urandom_range(0, 3))
      0: return 8'h00;
      1: return 8'hff;
      default: return 8'($urandom);
    endcase
  endfunction

  task automatic mwr(logic [11:0] x, logic [7:0] v);
    if (x == 12'hff0) acc = v;
    else mem[x] = v;
  endtask

  task automatic op_nz(logic [15:0] w, logic [7:0] v, logic tofile);
    run(w);
    n = v[7];
    z = (v == 8'h00);
    if (tofile) mwr(ad, v);
    else acc = v;
  endtask

  task automatic mff(logic [11:0] src, logic [11:0] dst);
    logic [7:0] v;
    v = mrd(src);
    issue({4'hc, src});
    issue({4'hf, dst});
    check("move second word", gap, 4);
    settle;
    mwr(dst, v);  // no program-counter or stack byte exists here
  endtask

  task automatic chk_regs;
    reg_rd(8'h00, {24'h0, acc}, "acc");
    reg_rd(8'h04, {24'h0, bank_select_reg}, "bank");
    reg_rd(8'h08, {27'h0, n, 3'h0, z}, "status");
    reg_rd(8'h0c, {24'h0, pl}, "prod low");
    reg_rd(8'h10, {24'h0, ph}, "prod high");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #800_000;
    n_errors++;
    test_done;
  end

  initial begin
    logic [7:0]  k, f, m;
    logic        a, d;
    logic [11:0] s, dd;
    logic [1:0]  ix;
    int          op, g1;
    void'($urandom(32'ha5862523));
    repeat (2) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    @(posedge i_mclk);
    for (int i = 0; i < 8; i++) reg_rd(8'(i * 4), 32'h0, "reset value");
    reg_rd(8'h24, 32'h0, "unmapped");
    bus_wr(8'h24, 32'hff);
    reg_rd(8'h24, 32'h0, "unmapped");
    bus_wr(8'h00, 32'h1a5);
    bus_wr(8'h1c, 32'hfabc);
    reg_rd(8'h1c, 32'habc, "pointer2");
    // clock enable low freezes the register port
    i_ce <= 1'b0;
    bus_wr(8'h00, 32'h3c);
    i_ce <= 1'b1;
    reg_rd(8'h00, 32'ha5, "acc frozen");
    @(negedge i_mclk);
    check("rdata idle", o_rdata, 32'h0);
    @(posedge i_mclk);
    issue({8'h0e, 8'h9a});
    issue({8'h09, 8'h35});
    check("one-word spacing", gap, 4);
    settle;
    acc = 8'hbf;
    n = 1'b1;
    chk_regs;
    issue({8'h0e, 8'h00}, 1'b1);
    settle;
    issue({4'hc, 12'hff0}, 1'b1);
    issue({4'hf, 12'h123}, 1'b1);
    g1 = gap;
    issue({8'h0e, 8'h12});
    check("skipped move span", g1 + gap, 8);
    settle;
    acc = 8'h12;
    chk_regs;
    repeat (300) begin
      op = $urandom_range(0, 9);
      k = pick();
      f = pick();
      a = 1'($urandom_range(0, 1));
      d = 1'($urandom_range(0, 1));
      ad = fa(f, a);
      if (op inside {1, 3, 9} && $isunknown(mrd(ad))) begin
        run({7'b0110111, a, f});
        mwr(ad, acc);
      end
      m = mrd(ad);
      case (op)
        0: op_nz({8'h09, k}, acc | k, 1'b0);
        1: op_nz({6'b000100, d, a, f}, acc | m, d);
        2: begin
          ix = 2'($urandom_range(0, 2));
          s = 12'($urandom);
          issue({8'hee, 2'b00, ix, s[11:8]});
          issue({8'hf0, s[7:0]});
          check("pointer second word", gap, 4);
          settle;
          reg_rd(8'h14 + {4'h0, ix, 2'b00}, {20'h0, s}, "pointer");
        end
        3: op_nz({6'b010100, d, a, f}, m, d);
        4: begin
          s = 12'($urandom);
          dd = 12'($urandom);
          if ($isunknown(mrd(s))) mff(12'hff0, s);
          mff(s, dd);
        end
        5: begin
          run({8'h01, k});
          bank_select_reg = k;
        end
        6: begin
          run({8'h0e, k});
          acc = k;
        end
        7: begin
          run({7'b0110111, a, f});
          mwr(ad, acc);
        end
        8: begin
          run({8'h0d, k});
          {ph, pl} = acc * k;
        end
        default: begin
          run({7'b0000001, a, f});
          {ph, pl} = acc * m;
        end
      endcase
      chk_regs;
    end
    test_done;
  end
endmodule
